// *** pmc_defines.vh ***
/*
  Constants of the power mode control register block: register offsets,
  field positions, reset values and encodings.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// ==========================================================================
// Register offsets
`define PMC_ADDR_POWER_MODE_CONTROL   8'h87
`define PMC_ADDR_SLEEP_CONTROL_STATUS 8'hBE

// ==========================================================================
// Power mode control fields
`define PMC_POWER_MODE_CONTROL_STROBE_BIT   0
`define PMC_POWER_MODE_CONTROL_RESV_BIT     1
`define PMC_POWER_MODE_CONTROL_RESET        8'h00

// ==========================================================================
// Sleep control fields
`define PMC_SLP_USB_EN_BIT    7
`define PMC_SLP_FAST_CRYSTAL_STABLE_BIT  6
`define PMC_SLP_FAST_RC_STABLE_BIT  5
`define PMC_SLP_CAUSE_HI      4
`define PMC_SLP_CAUSE_LO      3
`define PMC_SLP_PD_BIT        2
`define PMC_SLP_MODE_HI       1
`define PMC_SLP_MODE_LO       0
`define PMC_USB_EN_RESET      1'h0
`define PMC_PD_RESET          1'h1
`define PMC_MODE_RESET        2'h0

// ==========================================================================
// Timing counts
// Edges after reset release before the cause levels leave the synchroniser
`define PMC_CAUSE_WAIT        2'h2

// ==========================================================================
// Encodings
`define PMC_MODE_IDLE         2'h0
`define PMC_MODE_ONE          2'h1
`define PMC_MODE_TWO          2'h2
`define PMC_MODE_THREE        2'h3
`define PMC_CAUSE_POWER_ON    2'h0
`define PMC_CAUSE_EXTERNAL    2'h1
`define PMC_CAUSE_WATCHDOG    2'h2

`endif

// *** pmc_sync.v ***
/*
  Two-flop synchroniser for a vector of level inputs.
  Assumes the inputs are quasi-static levels from outside the clock domain.
*/
`timescale 1ns/1ps

module pmc_sync
#(
  parameter WIDTH = 4
)
(
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_arst_n,
  // Levels
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] stage1;

  // ========================================================================
  // Synchroniser chain, first stage read only by the second
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stage1 <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule // pmc_sync

// *** pmc_power_mode_control_regs.v ***
/*
  Power management registers: power mode control strobe and sleep control
  and status register, with the power mode sequencer they steer.
  Assumes a byte-wide register port on i_clk; oscillator, calibration and
  reset-cause inputs are asynchronous levels and are synchronised here.
  Deep power modes do not reset this block; state is kept unless noted.
*/
`timescale 1ns/1ps
`include "pmc_defines.vh"

module pmc_power_mode_control_regs
(
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_arst_n,
  // Register port
  input  wire [7:0] i_addr,
  input  wire       i_wr,
  input  wire [7:0] i_wdata,
  output reg  [7:0] o_rdata,
  // Wake and clock control from the system
  input  wire       i_irq,
  input  wire       i_system_clock_source_select,
  // Asynchronous status levels
  input  wire       i_fast_crystal_stable_raw,
  input  wire       i_fast_rc_stable_raw,
  input  wire       i_calibration_busy,
  input  wire       i_reset_external,
  input  wire       i_reset_watchdog,
  // Power control outputs
  output wire       o_cpu_halt,
  output wire       o_cpu_idle_mode,
  output wire       o_low_power_mode_one,
  output wire       o_low_power_mode_two,
  output wire       o_low_power_mode_three,
  output wire       o_usb_enable,
  output wire       o_fast_crystal_powerdown,
  output wire       o_fast_rc_powerdown
);

  // ========================================================================
  // State codes, one-hot
  localparam ST_ACTIVE = 5'h01;
  localparam ST_IDLE   = 5'h02;
  localparam ST_PM1    = 5'h04;
  localparam ST_PM2    = 5'h08;
  localparam ST_PM3    = 5'h10;

  reg  [4:0] state;
  reg  [4:0] next_state;
  reg        usb_enable;
  reg        spare_oscillator_powerdown;
  reg        powerdown_pending;
  reg  [1:0] power_mode;
  reg  [1:0] reset_cause;
  reg        cause_taken;
  reg        clk_sel_q;
  reg        sel_primed;
  reg  [1:0] cause_wait;
  reg        resv_halt;
  wire [4:0] sync_out;
  wire       fast_crystal_stable;
  wire       fast_rc_stable;
  wire       cal_busy;
  wire       ext_rst;
  wire       wdt_rst;
  wire       wr_power_mode_control;
  wire       wr_sleep;
  wire       strobe;
  wire       deep_exit;
  wire       clk_sel_toggle;

  // ========================================================================
  // Synchronise asynchronous levels
  pmc_sync #(.WIDTH(5)) u_sync
  (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  ({i_fast_crystal_stable_raw, i_fast_rc_stable_raw,
                i_calibration_busy, i_reset_external, i_reset_watchdog}),
    .o_sync   (sync_out)
  );

  assign fast_crystal_stable = sync_out[4];
  assign fast_rc_stable      = sync_out[3];
  assign cal_busy            = sync_out[2];
  assign ext_rst             = sync_out[1];
  assign wdt_rst             = sync_out[0];

  // ========================================================================
  // Write decode
  assign wr_power_mode_control  = i_wr && (i_addr == `PMC_ADDR_POWER_MODE_CONTROL);
  assign wr_sleep = i_wr && (i_addr == `PMC_ADDR_SLEEP_CONTROL_STATUS);
  assign strobe   = wr_power_mode_control && i_wdata[`PMC_POWER_MODE_CONTROL_STROBE_BIT];
  // First edge after reset only loads the select, so no false toggle
  assign clk_sel_toggle = sel_primed &&
                          (i_system_clock_source_select ^ clk_sel_q);
  assign deep_exit = i_irq && ((state == ST_PM2) || (state == ST_PM3));

  // ========================================================================
  // Power mode sequencer
  always @*
  begin
    next_state = state;
    case (state)
      ST_ACTIVE:
      begin
        if (strobe && !i_irq)
        begin
          case (power_mode)
            `PMC_MODE_ONE:   next_state = ST_PM1;
            `PMC_MODE_TWO:   next_state = ST_PM2;
            `PMC_MODE_THREE: next_state = ST_PM3;
            default:         next_state = ST_IDLE;
          endcase
        end
      end
      ST_IDLE, ST_PM1, ST_PM2, ST_PM3:
      begin
        if (i_irq)
          next_state = ST_ACTIVE;
      end
      default:
        next_state = ST_ACTIVE;
    endcase
  end

  // The device clock keeps running in this model, so a mode is a state flag
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      state <= ST_ACTIVE;
    else
      state <= next_state;
  end

  // ========================================================================
  // Reserved halt bit: software must not set it; once set the CPU stops
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      resv_halt <= 1'b0;
    else if (wr_power_mode_control && i_wdata[`PMC_POWER_MODE_CONTROL_RESV_BIT])
      resv_halt <= 1'b1;
  end

  // ========================================================================
  // Sleep control register
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      usb_enable                 <= `PMC_USB_EN_RESET;
      spare_oscillator_powerdown <= `PMC_PD_RESET;
      powerdown_pending          <= 1'b0;
      power_mode                 <= `PMC_MODE_RESET;
      clk_sel_q                  <= 1'b0;
      sel_primed                 <= 1'b0;
    end
    else
    begin
      clk_sel_q <= i_system_clock_source_select;
      sel_primed <= 1'b1;
      // USB enable clears on a wake from mode two or three, the mode field on entering modes one to three; other bits hold
      if (deep_exit)
        usb_enable <= 1'b0;
      else if (wr_sleep)
        usb_enable <= i_wdata[`PMC_SLP_USB_EN_BIT];
      if (wr_sleep)
        power_mode <= i_wdata[`PMC_SLP_MODE_HI:`PMC_SLP_MODE_LO];
      if ((state == ST_ACTIVE) && (next_state != ST_ACTIVE) &&
          (next_state != ST_IDLE))
        power_mode <= `PMC_MODE_IDLE;
      // Toggle of the clock select wins over a write in the same cycle
      if (clk_sel_toggle)
      begin
        spare_oscillator_powerdown <= 1'b0;
        powerdown_pending          <= 1'b0;
      end
      else if (wr_sleep && !i_wdata[`PMC_SLP_PD_BIT])
      begin
        spare_oscillator_powerdown <= 1'b0;
        powerdown_pending          <= 1'b0;
      end
      else if ((wr_sleep && i_wdata[`PMC_SLP_PD_BIT]) || powerdown_pending)
      begin
        if (cal_busy)
          powerdown_pending <= 1'b1;
        else
        begin
          spare_oscillator_powerdown <= 1'b1;
          powerdown_pending          <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // Reset cause, caught once after release; the source levels are sampled
  // as held by the reset controller at that time. Watchdog wins a tie.
  // Waits out the synchroniser, else the cause would always read zero.
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      reset_cause <= `PMC_CAUSE_POWER_ON;
      cause_taken <= 1'b0;
      cause_wait  <= 2'h0;
    end
    else if (!cause_taken && (cause_wait != `PMC_CAUSE_WAIT))
      cause_wait <= cause_wait + 2'h1;
    else if (!cause_taken)
    begin
      cause_taken <= 1'b1;
      if (wdt_rst)
        reset_cause <= `PMC_CAUSE_WATCHDOG;
      else if (ext_rst)
        reset_cause <= `PMC_CAUSE_EXTERNAL;
      else
        reset_cause <= `PMC_CAUSE_POWER_ON;
    end
  end

  // ========================================================================
  // Read data; strobe and reserved bit read zero, status bits not writable
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= 8'h00;
    else if (i_addr == `PMC_ADDR_POWER_MODE_CONTROL)
      o_rdata <= `PMC_POWER_MODE_CONTROL_RESET;
    else if (i_addr == `PMC_ADDR_SLEEP_CONTROL_STATUS)
      o_rdata <= {usb_enable,
                  fast_crystal_stable && !o_fast_crystal_powerdown,
                  fast_rc_stable && !o_fast_rc_powerdown,
                  reset_cause,
                  spare_oscillator_powerdown,
                  power_mode};
    else
      o_rdata <= 8'h00;
  end

  // ========================================================================
  // Outputs; select zero picks the crystal, one the RC oscillator
  assign o_cpu_halt             = (state != ST_ACTIVE) || resv_halt;
  assign o_cpu_idle_mode        = (state == ST_IDLE);
  assign o_low_power_mode_one   = (state == ST_PM1);
  assign o_low_power_mode_two   = (state == ST_PM2);
  assign o_low_power_mode_three = (state == ST_PM3);
  assign o_usb_enable           = usb_enable;
  // Both run while the bit is zero; only the spare stops when it is one
  assign o_fast_crystal_powerdown = spare_oscillator_powerdown &&
                                    i_system_clock_source_select;
  assign o_fast_rc_powerdown      = spare_oscillator_powerdown &&
                                    !i_system_clock_source_select;

endmodule // pmc_power_mode_control_regs

// *** pmc_props.sv ***
/*
  Port checker of the power mode register block.
  Assumes one clock domain and a bind onto the design top.
*/
`timescale 1ns/1ps

module pmc_props
(
  // Clock, reset and register port
  input wire       i_clk,
  input wire       i_arst_n,
  input wire [7:0] i_addr,
  input wire       i_wr,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  // Control and status
  input wire       i_irq,
  input wire       i_system_clock_source_select,
  input wire       o_cpu_halt,
  input wire       o_cpu_idle_mode,
  input wire       o_low_power_mode_one,
  input wire       o_low_power_mode_two,
  input wire       o_low_power_mode_three,
  input wire       o_usb_enable,
  input wire       o_fast_crystal_powerdown,
  input wire       o_fast_rc_powerdown
);
  // ==========================================================================
  // Sequences
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire [3:0] mode_v = {o_low_power_mode_three, o_low_power_mode_two,
                       o_low_power_mode_one, o_cpu_idle_mode};
  wire       sel    = i_system_clock_source_select;
  sequence s_strobe;
    i_wr && i_addr == 8'h87 && i_wdata[0] && !i_irq;
  endsequence
  // A wake from the two deepest modes, with no write racing it
  sequence s_deep_wake;
    (o_low_power_mode_two || o_low_power_mode_three) && i_irq && !i_wr;
  endsequence
  // ==========================================================================
  // Assertions
  chk_strobe_enter:
    assert property (s_strobe |=> o_cpu_halt && mode_v != 4'h0)
    else $error("strobe did not enter a power mode");
  chk_irq_wake:
    assert property (i_irq |=> mode_v == 4'h0)
    else $error("interrupt did not return to active");
  chk_strobe_reads:
    assert property ($past(i_addr) == 8'h87 |-> o_rdata[1:0] == 2'h0)
    else $error("strobe or reserved bit read as one");
  chk_usb_write:
    assert property (i_wr && i_addr == 8'hBE && !i_irq
                     |=> o_usb_enable == $past(i_wdata[7]))
    else $error("usb enable does not follow write");
  chk_usb_wake_clr:
    assert property (s_deep_wake |=> !o_usb_enable)
    else $error("usb enable kept after deep wake");
  chk_mode_hold:
    assert property (o_low_power_mode_two && !i_irq |=> o_low_power_mode_two)
    else $error("mode two left without interrupt");
  chk_xosc_pd_sel:
    assert property (o_fast_crystal_powerdown |-> sel && !o_fast_rc_powerdown)
    else $error("selected crystal powered down");
  chk_rc_pd_sel:
    assert property (o_fast_rc_powerdown |-> !sel)
    else $error("selected rc oscillator powered down");
  chk_toggle_clear:
    assert property (!$stable(sel)
                     |=> !o_fast_crystal_powerdown && !o_fast_rc_powerdown)
    else $error("select toggle left power-down set");
  chk_rsv_halt:
    assert property (i_wr && i_addr == 8'h87 && i_wdata[1] |=> o_cpu_halt[*8])
    else $error("reserved write did not halt");
endmodule // pmc_props

bind pmc_power_mode_control_regs pmc_props u_props (.i_clk(i_clk),
  .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .i_irq(i_irq),
  .i_system_clock_source_select(i_system_clock_source_select),
  .o_cpu_halt(o_cpu_halt), .o_cpu_idle_mode(o_cpu_idle_mode),
  .o_low_power_mode_one(o_low_power_mode_one),
  .o_low_power_mode_two(o_low_power_mode_two),
  .o_low_power_mode_three(o_low_power_mode_three),
  .o_usb_enable(o_usb_enable),
  .o_fast_crystal_powerdown(o_fast_crystal_powerdown),
  .o_fast_rc_powerdown(o_fast_rc_powerdown));

// *** pmc_power_mode_control_regs_test.sv ***
/*
  Self-checking bench of the power mode register block.
  Assumes reads answer one cycle after the address, writes at the next edge.
*/
`timescale 1ns/1ps

module pmc_power_mode_control_regs_test;
  // ==========================================================================
  // Stimulus and observed pins
  reg        i_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_irq = 1'b0;
  reg  [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  reg        sel = 1'b0, xs = 1'b1, rs = 1'b1, cal = 1'b0;
  reg        rext = 1'b0, rwdt = 1'b0;
  wire [7:0] o_rdata;
  wire       halt, m0, m1, m2, m3, usb, xpd, rpd;
  wire [7:0] pins = {halt, usb, xpd, rpd, m3, m2, m1, m0};
  integer    err_total = 0, cmp_count = 0, cyc = 0, m;

  pmc_power_mode_control_regs dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_irq(i_irq), .i_system_clock_source_select(sel),
    .i_fast_crystal_stable_raw(xs), .i_fast_rc_stable_raw(rs),
    .i_calibration_busy(cal), .i_reset_external(rext),
    .i_reset_watchdog(rwdt), .o_cpu_halt(halt), .o_cpu_idle_mode(m0),
    .o_low_power_mode_one(m1), .o_low_power_mode_two(m2),
    .o_low_power_mode_three(m3), .o_usb_enable(usb),
    .o_fast_crystal_powerdown(xpd), .o_fast_rc_powerdown(rpd));

  // ==========================================================================
  // Clock, timeout and verdict
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 1000)
    begin
      err_total = err_total + 1;
      final_report;
    end
  end
  task final_report;
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Access tasks, all driven from the falling edge
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_clk);
    i_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_clk);
    i_addr = a;
    @(negedge i_clk);
    cmp(o_rdata, e);
  endtask
  task automatic pin(input logic [7:0] e);
    cmp(pins, e);
  endtask
  task automatic irq;
    @(negedge i_clk);
    i_irq = 1'b1;
    @(negedge i_clk);
    i_irq = 1'b0;
  endtask
  // Wait out the status synchronisers before anything is read
  task automatic rst;
    i_arst_n = 1'b0;
    repeat (8) @(negedge i_clk);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask

  // ==========================================================================
  // Tests
  initial
  begin
    rst;
    rd(8'hBE, 8'h44);
    pin(8'h10);
    rd(8'h87, 8'h00);
    rd(8'h10, 8'h00);
    for (m = 0; m < 4; m = m + 1)
    begin
      wr(8'hBE, 8'hFC | m[7:0]);
      rd(8'hBE, 8'hC4 | m[7:0]);
      wr(8'h87, 8'h01);
      pin(8'hD0 | (8'h01 << m));
      rd(8'hBE, 8'hC4);
      rd(8'h87, 8'h00);
      irq;
      pin(m < 2 ? 8'h50 : 8'h10);
    end
    wr(8'hBE, 8'h00);
    repeat (3) @(negedge i_clk);
    rd(8'hBE, 8'h60);
    pin(8'h00);
    cal = 1'b1;
    repeat (3) @(negedge i_clk);
    wr(8'hBE, 8'h04);
    rd(8'hBE, 8'h60);
    cal = 1'b0;
    repeat (4) @(negedge i_clk);
    rd(8'hBE, 8'h44);
    sel = 1'b1;
    repeat (4) @(negedge i_clk);
    rd(8'hBE, 8'h60);
    wr(8'hBE, 8'h04);
    pin(8'h20);
    sel = 1'b0;
    wr(8'h87, 8'h02);
    irq;
    pin(8'h80);
    for (m = 1; m < 3; m = m + 1)
    begin
      rext = (m == 1);
      rwdt = (m == 2);
      rst;
      rext = 1'b0;
      rwdt = 1'b0;
      rd(8'hBE, 8'h44 | (m[7:0] << 3));
      pin(8'h10);
    end
    final_report;
  end
endmodule // pmc_power_mode_control_regs_test
